/* File: design/fbl_pkg.sv */
// shared constants and carriers for the block lock / reset / id command logic
package fbl_pkg;

  // address layout
  localparam int ADDR_W      = 24;
  localparam int BLK_LSB     = 16;
  localparam int SEC_LSB     = 12;
  localparam int BLK_W       = ADDR_W - BLK_LSB;
  localparam int SEC_W       = BLK_LSB - SEC_LSB;
  localparam int SEC_PER_BLK = 1 << SEC_W;

  // opcodes
  localparam logic [7:0] OPC_WRITE_ENABLE_CMD    = 8'h06;
  localparam logic [7:0] OPC_UNLOCK1 = 8'h39;
  localparam logic [7:0] OPC_LKREAD  = 8'h3d;
  localparam logic [7:0] OPC_LOCKALL = 8'h7e;
  localparam logic [7:0] OPC_FREEALL = 8'h98;
  localparam logic [7:0] OPC_RSTARM  = 8'h66;
  localparam logic [7:0] OPC_RST     = 8'h99;
  localparam logic [7:0] OPC_UIDRD   = 8'h4b;
  localparam logic [7:0] OPC_TBLRD   = 8'h5a;

  // phase lengths in bytes
  localparam logic [3:0] ADDR_BYTES = 4'h3;
  localparam logic [3:0] UID_DUMMY  = 4'h4;
  localparam logic [3:0] TBL_DUMMY  = 4'h1;

  // timing
  localparam int CLK_MHZ          = 200;
  localparam int RST_LOW_MIN_NS   = 1000;
  localparam int RST_LOW_CYC_INT  = (RST_LOW_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam logic [15:0] RST_LOW_CYC = 16'(RST_LOW_CYC_INT);

  // sync reset value: reset pin high, select high, clock low, data low
  localparam logic [6:0] PIN_RST_VAL = 7'h60;

  typedef enum logic [1:0] {LK_NONE, LK_CLR_ONE, LK_SET_ALL, LK_CLR_ALL} fbl_lock_op_t;

  typedef struct packed {
    logic [BLK_W-1:0] blk;
    logic [SEC_W-1:0] sec;
  } fbl_loc_t;

  typedef struct packed {
    fbl_lock_op_t op;
    fbl_loc_t     loc;
  } fbl_lock_req_t;

endpackage : fbl_pkg

/* File: design/fbl_sync.sv */
// two-flop synchroniser for pins entering the core clock domain
`timescale 1ns/1ps
`default_nettype none
module fbl_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= RST_VAL;
      q_o      <= RST_VAL;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule : fbl_sync
`default_nettype wire

/* File: design/fbl_lock_array.sv */
// volatile lock bits, one per 4 KB sector, grouped by 64 KB block
`timescale 1ns/1ps
`default_nettype none
module fbl_lock_array import fbl_pkg::*; #(
  parameter int NBLK = 1 << BLK_W
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  // update request
  input  wire fbl_lock_req_t req_i,
  // two read ports
  input  wire fbl_loc_t      rd0_i,
  output logic               rd0_lock_o,
  input  wire fbl_loc_t      rd1_i,
  output logic               rd1_lock_o
);
  logic [SEC_PER_BLK-1:0] lock_reg [NBLK];

  // outer blocks are sector-granular, inner ones lock as a whole
  function automatic logic fine_blk(input logic [BLK_W-1:0] b);
    fine_blk = (b == '0) || (b == BLK_W'(NBLK - 1));
  endfunction : fine_blk

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NBLK; i++) lock_reg[i] <= '1;
    end else begin
      unique case (req_i.op)
        LK_CLR_ONE: begin
          if (fine_blk(req_i.loc.blk)) begin
            lock_reg[req_i.loc.blk][req_i.loc.sec] <= 1'b0;
          end else begin
            lock_reg[req_i.loc.blk] <= '0;
          end
        end
        LK_SET_ALL: for (int i = 0; i < NBLK; i++) lock_reg[i] <= '1;
        LK_CLR_ALL: for (int i = 0; i < NBLK; i++) lock_reg[i] <= '0;
        LK_NONE: ;
      endcase
    end
  end

  assign rd0_lock_o = lock_reg[rd0_i.blk][rd0_i.sec];
  assign rd1_lock_o = lock_reg[rd1_i.blk][rd1_i.sec];
endmodule : fbl_lock_array
`default_nettype wire

/* File: design/fbl_cmd.sv */
// serial flash command logic for block locks, resets, unique id and parameter table
`timescale 1ns/1ps
`default_nettype none
module fbl_cmd import fbl_pkg::*; #(
  parameter logic [127:0] UNIQUE_ID = 128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff // arbitrary
) (
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              nrst_i,
  // serial pins
  input  wire logic              cs_n_i,
  input  wire logic              sclk_i,
  input  wire logic [3:0]        io_i,
  output logic      [3:0]        io_o,
  output logic      [3:0]        io_oe_o,
  input  wire logic              reset_pin_n_i,
  // configuration bits
  input  wire logic              quad_command_mode_i,
  input  wire logic              protect_scheme_select_i,
  input  wire logic              protect_complement_bit_i,
  input  wire logic [4:0]        block_protect_field_i,
  // array engine side
  input  wire logic              write_in_progress_flag_i,
  input  wire logic [ADDR_W-1:0] check_addr_i,
  output logic                   check_locked_o,
  output logic                   op_abort_o,
  output logic                   dev_reset_o,
  output logic                   write_enable_latch_o,
  // parameter table source
  output logic      [ADDR_W-1:0] table_addr_o,
  input  wire logic [7:0]        table_data_i
);
  typedef enum logic [2:0] {ST_IDLE, ST_OPC, ST_ADDR, ST_DUMMY, ST_DOUT, ST_SKIP} fbl_state_t;
  function automatic logic [3:0] addr_len(input logic [7:0] op);
    addr_len = (op == OPC_UNLOCK1 || op == OPC_LKREAD || op == OPC_TBLRD) ? ADDR_BYTES : 4'h0;
  endfunction : addr_len
  function automatic logic [3:0] dummy_len(input logic [7:0] op);
    dummy_len = (op == OPC_UIDRD) ? UID_DUMMY : (op == OPC_TBLRD) ? TBL_DUMMY : 4'h0;
  endfunction : dummy_len
  function automatic logic is_read(input logic [7:0] op);
    is_read = (op == OPC_LKREAD || op == OPC_UIDRD || op == OPC_TBLRD);
  endfunction : is_read
  // reset release
  logic [1:0] rst_ff;
  logic       rst_n;
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_ff <= 2'b00;
    end else begin
      rst_ff <= {rst_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_ff[1];
  // pin sampling
  logic       pin_n_s;
  logic       cs_n_s;
  logic       sclk_s;
  logic [3:0] io_s;
  fbl_sync #(
    .W       (7),
    .RST_VAL (PIN_RST_VAL)
  ) u_sync (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n),
    .d_i     ({reset_pin_n_i, cs_n_i, sclk_i, io_i}),
    .q_o     ({pin_n_s, cs_n_s, sclk_s, io_s})
  );
  logic sclk_d_reg;
  logic cs_d_reg;
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d_reg <= 1'b0;
      cs_d_reg   <= 1'b1;
    end else begin
      sclk_d_reg <= sclk_s;
      cs_d_reg   <= cs_n_s;
    end
  end
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  assign sclk_rise = sclk_s & ~sclk_d_reg & ~cs_n_s & pin_n_s;
  assign sclk_fall = ~sclk_s & sclk_d_reg & ~cs_n_s & pin_n_s;
  assign cs_rise   = cs_n_s & ~cs_d_reg;
  // reset pin width check
  logic [15:0] pin_low_reg;
  logic        hw_rst_go;
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_low_reg <= '0;
    end else if (pin_n_s) begin
      pin_low_reg <= '0;
    end else if (pin_low_reg != RST_LOW_CYC) begin
      pin_low_reg <= pin_low_reg + 16'd1;
    end
  end
  // fires once per low pulse, so a long hold does not retrigger
  assign hw_rst_go = !pin_n_s && (pin_low_reg == RST_LOW_CYC - 16'd1);
  // command shifter state
  fbl_state_t        state_reg;
  logic [2:0]        bit_reg;
  logic [3:0]        cnt_reg;
  logic [7:0]        sh_reg;
  logic [7:0]        op_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [7:0]        shin;
  logic [2:0]        bit_next;
  logic              byte_done;
  // single-line mode looks at the first data line only
  assign shin      = quad_command_mode_i ? {sh_reg[3:0], io_s} : {sh_reg[6:0], io_s[0]};
  assign bit_next  = bit_reg + (quad_command_mode_i ? 3'd4 : 3'd1);
  assign byte_done = sclk_rise && (bit_next == 3'd0);
  logic wel_reg;
  logic arm_reg;
  logic exec_ok;
  logic wr_go;
  logic wen_go;
  logic arm_go;
  logic soft_go;
  logic dev_rst_go;
  assign exec_ok    = cs_rise && pin_n_s && (bit_reg == 3'd0) && (state_reg == ST_SKIP);
  assign wr_go      = exec_ok && wel_reg && (op_reg == OPC_UNLOCK1 ||
                      op_reg == OPC_LOCKALL || op_reg == OPC_FREEALL);
  assign wen_go     = exec_ok && (op_reg == OPC_WRITE_ENABLE_CMD);
  assign arm_go     = exec_ok && (op_reg == OPC_RSTARM);
  assign soft_go    = exec_ok && (op_reg == OPC_RST) && arm_reg;
  assign dev_rst_go = soft_go || hw_rst_go;
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      bit_reg   <= 3'd0;
      cnt_reg   <= 4'h0;
      sh_reg    <= 8'h00;
      op_reg    <= 8'h00;
      addr_reg  <= '0;
    end else if (dev_rst_go || cs_n_s || !pin_n_s) begin
      state_reg <= ST_IDLE;
      bit_reg   <= 3'd0;
      cnt_reg   <= 4'h0;
    end else if (state_reg == ST_IDLE) begin
      state_reg <= ST_OPC;
    end else if (sclk_rise) begin
      sh_reg  <= shin;
      bit_reg <= bit_next;
      if (bit_next == 3'd0) begin
        unique case (state_reg)
          ST_OPC: begin
            op_reg  <= shin;
            cnt_reg <= 4'h0;
            if (addr_len(shin) != 4'h0) begin
              state_reg <= ST_ADDR;
            end else if (dummy_len(shin) != 4'h0) begin
              state_reg <= ST_DUMMY;
            end else begin
              state_reg <= ST_SKIP;
            end
          end
          ST_ADDR: begin
            addr_reg <= {addr_reg[ADDR_W-9:0], shin};
            cnt_reg  <= cnt_reg + 4'h1;
            if (cnt_reg == addr_len(op_reg) - 4'h1) begin
              cnt_reg <= 4'h0;
              if (dummy_len(op_reg) != 4'h0) begin
                state_reg <= ST_DUMMY;
              end else if (is_read(op_reg)) begin
                state_reg <= ST_DOUT;
              end else begin
                state_reg <= ST_SKIP;
              end
            end
          end
          ST_DUMMY: begin
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == dummy_len(op_reg) - 4'h1) begin
              cnt_reg   <= 4'h0;
              state_reg <= ST_DOUT;
            end
          end
          ST_DOUT: cnt_reg <= cnt_reg + 4'h1;
          ST_SKIP: ;
          ST_IDLE: ;
        endcase
      end
    end
  end
  // write enable latch
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wel_reg <= 1'b0;
    end else if (dev_rst_go) begin
      wel_reg <= 1'b0;
    end else if (wen_go) begin
      wel_reg <= 1'b1;
    end else if (wr_go) begin
      wel_reg <= 1'b0;
    end
  end
  // reset arm: any opcode other than the reset itself cancels it
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      arm_reg <= 1'b0;
    end else if (dev_rst_go) begin
      arm_reg <= 1'b0;
    end else if (arm_go) begin
      arm_reg <= 1'b1;
    end else if (byte_done && state_reg == ST_OPC && shin != OPC_RST) begin
      arm_reg <= 1'b0;
    end
  end
  // lock bit storage
  fbl_lock_req_t lk_req_reg;
  logic          lock_rd0;
  logic          lock_rd1;
  fbl_loc_t      rd_loc;
  fbl_loc_t      chk_loc;
  assign rd_loc  = '{blk: addr_reg[ADDR_W-1:BLK_LSB], sec: addr_reg[BLK_LSB-1:SEC_LSB]};
  assign chk_loc = '{blk: check_addr_i[ADDR_W-1:BLK_LSB], sec: check_addr_i[BLK_LSB-1:SEC_LSB]};
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lk_req_reg <= '{op: LK_NONE, loc: '0};
    end else if (dev_rst_go) begin
      lk_req_reg <= '{op: LK_SET_ALL, loc: '0};
    end else if (wr_go && op_reg == OPC_UNLOCK1) begin
      lk_req_reg <= '{op: LK_CLR_ONE, loc: rd_loc};
    end else if (wr_go && op_reg == OPC_LOCKALL) begin
      lk_req_reg <= '{op: LK_SET_ALL, loc: '0};
    end else if (wr_go) begin
      lk_req_reg <= '{op: LK_CLR_ALL, loc: '0};
    end else begin
      lk_req_reg <= '{op: LK_NONE, loc: '0};
    end
  end
  fbl_lock_array u_locks (
    .clk_i      (core_clk_i),
    .rst_n_i    (rst_n),
    .req_i      (lk_req_reg),
    .rd0_i      (rd_loc),
    .rd0_lock_o (lock_rd0),
    .rd1_i      (chk_loc),
    .rd1_lock_o (lock_rd1)
  );
  // protect-field scheme, simplified: upper 2^(n-1) blocks, complement inverts
  logic [BLK_W:0] bp_span;
  logic           bp_hit;
  logic           bp_prot;
  assign bp_span = (block_protect_field_i > 5'(BLK_W)) ? (BLK_W+1)'(1 << BLK_W) :
                   (BLK_W+1)'(1) << (block_protect_field_i - 5'd1);
  assign bp_hit  = (block_protect_field_i != 5'd0) &&
                   ({1'b0, chk_loc.blk} >= (BLK_W+1)'(1 << BLK_W) - bp_span);
  assign bp_prot = bp_hit ^ protect_complement_bit_i;
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      check_locked_o <= 1'b1;
    end else begin
      check_locked_o <= protect_scheme_select_i ? lock_rd1 : bp_prot;
    end
  end
  // read data path
  logic [7:0] fresh;
  logic [7:0] out_sh;
  logic [7:0] cur;

  always_comb begin
    unique case (op_reg)
      OPC_LKREAD: fresh = {7'h00, lock_rd0};
      OPC_UIDRD:  fresh = UNIQUE_ID[{~cnt_reg, 3'b111} -: 8];
      default:    fresh = table_data_i;
    endcase
  end

  // new byte picked at its first falling edge, giving the table source time
  assign cur = (bit_reg == 3'd0) ? fresh : out_sh;

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      io_o    <= 4'h0;
      io_oe_o <= 4'h0;
      out_sh  <= 8'h00;
    end else if (state_reg != ST_DOUT || cs_n_s || !pin_n_s) begin
      io_oe_o <= 4'h0;
    end else if (sclk_fall) begin
      out_sh <= cur;
      if (quad_command_mode_i) begin
        io_o    <= bit_reg[2] ? cur[3:0] : cur[7:4];
        io_oe_o <= 4'hf;
      end else begin
        io_o    <= {2'b00, cur[3'd7 - bit_reg], 1'b0};
        io_oe_o <= 4'h2;
      end
    end
  end
  // table address follows the streamed bytes
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      table_addr_o <= '0;
    end else if (byte_done && state_reg == ST_ADDR) begin
      table_addr_o <= {addr_reg[ADDR_W-9:0], shin};
    end else if (byte_done && state_reg == ST_DOUT && op_reg == OPC_TBLRD) begin
      table_addr_o <= table_addr_o + ADDR_W'(1);
    end
  end
  // reset and abort pulses to the array engine
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      op_abort_o  <= 1'b0;
      dev_reset_o <= 1'b0;
    end else begin
      op_abort_o  <= dev_rst_go && write_in_progress_flag_i;
      dev_reset_o <= dev_rst_go;
    end
  end

  assign write_enable_latch_o = wel_reg;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n);

  a_oe_pin_reset: assert property (!pin_n_s |=> io_oe_o == 4'h0)
    else $error("data lines driven while reset pin low");
  a_exec_on_bound: assert property (wr_go |-> bit_reg == 3'd0 && state_reg == ST_SKIP)
    else $error("lock command ran off a byte boundary");
  a_exec_needs_wel: assert property (wr_go |-> wel_reg)
    else $error("lock command ran without write enable");
  a_wel_dropped: assert property (wr_go ##1 !wen_go |=> !write_enable_latch_o)
    else $error("write enable latch still set after lock command");
  a_arm_cancel: assert property (byte_done && state_reg == ST_OPC && shin != OPC_RST
                                 && !dev_rst_go |=> !arm_reg)
    else $error("reset arm survived another opcode");
  a_soft_needs_arm: assert property ($rose(dev_reset_o) && $past(pin_n_s)
                                     |-> $past(arm_reg))
    else $error("software reset without arm");
  a_all_locked: assert property (lk_req_reg.op == LK_SET_ALL |=> lock_rd1)
    else $error("lock bit clear after lock-all");
  a_all_free: assert property (lk_req_reg.op == LK_CLR_ALL |=> !lock_rd1)
    else $error("lock bit set after unlock-all");
  a_pin_width: assert property ($rose(dev_reset_o) && !$past(pin_n_s)
                                |-> pin_low_reg == RST_LOW_CYC)
    else $error("pin reset taken before minimum low time");
  a_abort_busy: assert property (dev_rst_go && write_in_progress_flag_i |=> op_abort_o)
    else $error("busy operation not aborted on reset");
  a_scheme_bp: assert property (!protect_scheme_select_i && !bp_prot |=> !check_locked_o)
    else $error("lock bits used while scheme select is 0");
endmodule : fbl_cmd
`default_nettype wire

/* File: verification/fbl_host.sv */
// host model: drives select, serial clock, data lines and reset pin of the flash command logic
`timescale 1ns/1ps
`default_nettype none
module fbl_host import fbl_pkg::*; (
  // mode and resolved data lines
  input  wire logic       quad_i,
  input  wire logic [3:0] io_i,
  // pins driven by the host
  output logic            cs_n_o,
  output logic            sclk_o,
  output logic            rst_pin_n_o,
  output logic [3:0]      drv_o
);
  logic [7:0] rx;

  initial begin
    cs_n_o      = 1'b1;
    sclk_o      = 1'b0;
    rst_pin_n_o = 1'b1;
    drv_o       = 4'h0;
  end

  // msb first; lines not carrying data toggle so stale levels never pass
  task automatic xfer(input logic [7:0] tx, output logic [7:0] r);
    r = 8'h00;
    for (int i = 0; i < (quad_i ? 2 : 8); i++) begin
      drv_o = quad_i ? tx[7-4*i -: 4] : {~drv_o[3:1], tx[7-i]};
      #24;
      r = quad_i ? {r[3:0], io_i} : {r[6:0], io_i[1]};
      sclk_o = 1'b1;
      #24;
      sclk_o = 1'b0;
    end
  endtask : xfer

  // one stray clock, used to break the byte boundary on purpose
  task automatic pulse();
    #24;
    sclk_o = 1'b1;
    #24;
    sclk_o = 1'b0;
  endtask : pulse

  task automatic send(input logic [7:0] op, input int na, input logic [23:0] a);
    cs_n_o = 1'b0;
    #30;
    xfer(op, rx);
    for (int i = 0; i < na; i++) xfer(a[23-8*i -: 8], rx);
  endtask : send

  task automatic stop();
    #30;
    cs_n_o = 1'b1;
    #100;
  endtask : stop

  task automatic cmd(input logic [7:0] op, input int na, input logic [23:0] a);
    send(op, na, a);
    stop();
  endtask : cmd

  task automatic wr_cmd(input logic [7:0] op, input int na, input logic [23:0] a);
    cmd(OPC_WRITE_ENABLE_CMD, 0, 24'h000000);
    cmd(op, na, a);
  endtask : wr_cmd

  task automatic pin(input logic v);
    rst_pin_n_o = v;
    if (v) #1000;
  endtask : pin

  task automatic recover();
    #30000;
  endtask : recover
endmodule : fbl_host
`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench for the block lock, reset and id command logic
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fbl_pkg::*;
  localparam logic [127:0] UID = 128'h5e71_0c2a_93b4_d6f8_1a3c_5e70_92b4_d6e8; // arbitrary
  logic              core_clk_i;
  logic              nrst_i;
  logic              cs_n_i, sclk_i, reset_pin_n_i;
  logic [3:0]        io_i, io_o, io_oe_o, drv;
  logic              quad_command_mode_i, protect_scheme_select_i, protect_complement_bit_i;
  logic [4:0]        block_protect_field_i;
  logic              write_in_progress_flag_i;
  logic [ADDR_W-1:0] check_addr_i, table_addr_o;
  logic              check_locked_o, op_abort_o, dev_reset_o, write_enable_latch_o;
  logic [7:0]        table_data_i = 8'h00;
  logic [127:0]      v;
  int                miscompares = 0, cmp_count = 0, rst_cnt = 0, ab_cnt = 0, n;

  assign io_i = (io_oe_o & io_o) | (~io_oe_o & drv);

  fbl_cmd #(.UNIQUE_ID(UID)) fbl_cmd_inst (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i),
    .io_i(io_i), .io_o(io_o), .io_oe_o(io_oe_o), .reset_pin_n_i(reset_pin_n_i),
    .quad_command_mode_i(quad_command_mode_i),
    .protect_scheme_select_i(protect_scheme_select_i),
    .protect_complement_bit_i(protect_complement_bit_i),
    .block_protect_field_i(block_protect_field_i),
    .write_in_progress_flag_i(write_in_progress_flag_i), .check_addr_i(check_addr_i),
    .check_locked_o(check_locked_o), .op_abort_o(op_abort_o), .dev_reset_o(dev_reset_o),
    .write_enable_latch_o(write_enable_latch_o), .table_addr_o(table_addr_o),
    .table_data_i(table_data_i)
  );

  fbl_host fbl_host_inst (
    .quad_i(quad_command_mode_i), .io_i(io_i), .cs_n_o(cs_n_i), .sclk_o(sclk_i),
    .rst_pin_n_o(reset_pin_n_i), .drv_o(drv)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  // table source answers the address with a fixed pattern
  always @(negedge core_clk_i) table_data_i <= table_addr_o[7:0] ^ 8'ha5;

  // counted mid-cycle, away from the edge that launches the pulses
  always @(negedge core_clk_i) begin
    if (dev_reset_o === 1'b1) rst_cnt++;
    if (op_abort_o === 1'b1) ab_cnt++;
  end

  task automatic chk(input string nm, input logic [127:0] s, input logic [127:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", nm, e, s);
    end
  endtask : chk

  task automatic lk(input logic [23:0] a, input logic e);
    @(negedge core_clk_i);
    check_addr_i = a;
    repeat (2) @(negedge core_clk_i);
    chk("check_locked_o", check_locked_o, e);
  endtask : lk

  task automatic mode(input logic q, input logic s, input logic c, input logic [4:0] f);
    @(negedge core_clk_i);
    quad_command_mode_i      = q;
    protect_scheme_select_i  = s;
    protect_complement_bit_i = c;
    block_protect_field_i    = f;
  endtask : mode

  task automatic rd(input logic [7:0] op, input logic [23:0] a, input int na, input int nd,
                    input int nb, output logic [127:0] r);
    logic [7:0] b;
    fbl_host_inst.send(op, na, a);
    repeat (nd) fbl_host_inst.xfer(8'hc3, b);
    r = '0;
    repeat (nb) begin
      fbl_host_inst.xfer(8'hc3, b);
      r = {r[119:0], b};
    end
    fbl_host_inst.stop();
  endtask : rd

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report

  initial begin
    #200000;
    miscompares++;
    final_report();
  end

  initial begin
    nrst_i = 1'b0;
    quad_command_mode_i = 1'b0;
    protect_scheme_select_i = 1'b1;
    protect_complement_bit_i = 1'b0;
    block_protect_field_i = 5'h00;
    write_in_progress_flag_i = 1'b0;
    check_addr_i = 24'h000000;
    repeat (10) @(negedge core_clk_i);
    nrst_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    lk(24'h050000, 1'b1);
    chk("wel", write_enable_latch_o, 1'b0);
    fbl_host_inst.cmd(OPC_FREEALL, 0, 24'h0);
    lk(24'h050000, 1'b1);
    fbl_host_inst.cmd(OPC_WRITE_ENABLE_CMD, 0, 24'h0);
    chk("wel", write_enable_latch_o, 1'b1);
    fbl_host_inst.cmd(OPC_FREEALL, 0, 24'h0);
    lk(24'hff3000, 1'b0);
    chk("wel", write_enable_latch_o, 1'b0);
    $display("test global_unlock done");
    mode(1'b1, 1'b1, 1'b0, 5'h00);
    fbl_host_inst.wr_cmd(OPC_LOCKALL, 0, 24'h0);
    lk(24'h050000, 1'b1);
    rd(OPC_LKREAD, 24'h050000, 3, 0, 1, v);
    chk("lock_status", v, 8'h01);
    mode(1'b0, 1'b1, 1'b0, 5'h00);
    $display("test quad_lock done");
    fbl_host_inst.wr_cmd(OPC_UNLOCK1, 3, 24'h05a000);
    lk(24'h05f000, 1'b0);
    lk(24'h060000, 1'b1);
    fbl_host_inst.wr_cmd(OPC_UNLOCK1, 3, 24'h001000);
    lk(24'h001fff, 1'b0);
    lk(24'h002000, 1'b1);
    rd(OPC_LKREAD, 24'h05a123, 3, 0, 1, v);
    chk("lock_status", v, 8'h00);
    rd(OPC_LKREAD, 24'h060000, 3, 0, 1, v);
    chk("lock_status", v, 8'h01);
    $display("test unlock_one done");
    fbl_host_inst.cmd(OPC_WRITE_ENABLE_CMD, 0, 24'h0);
    fbl_host_inst.send(OPC_UNLOCK1, 3, 24'h070000);
    fbl_host_inst.pulse();
    fbl_host_inst.stop();
    lk(24'h070000, 1'b1);
    chk("wel", write_enable_latch_o, 1'b1);
    $display("test boundary done");
    mode(1'b0, 1'b0, 1'b0, 5'h00);
    lk(24'h060000, 1'b0);
    mode(1'b0, 1'b0, 1'b0, 5'h01);
    lk(24'hff0000, 1'b1);
    lk(24'hfe0000, 1'b0);
    mode(1'b0, 1'b0, 1'b1, 5'h01);
    lk(24'hfe0000, 1'b1);
    mode(1'b0, 1'b1, 1'b0, 5'h00);
    $display("test scheme done");
    n = rst_cnt;
    fbl_host_inst.cmd(OPC_RSTARM, 0, 24'h0);
    fbl_host_inst.cmd(8'h05, 0, 24'h0);
    fbl_host_inst.cmd(OPC_RST, 0, 24'h0);
    chk("resets", rst_cnt, n);
    lk(24'h05f000, 1'b0);
    @(negedge core_clk_i);
    write_in_progress_flag_i = 1'b1;
    fbl_host_inst.cmd(OPC_RSTARM, 0, 24'h0);
    fbl_host_inst.cmd(OPC_RST, 0, 24'h0);
    chk("resets", rst_cnt, n + 1);
    chk("aborts", ab_cnt, 1);
    lk(24'h05f000, 1'b1);
    chk("wel", write_enable_latch_o, 1'b0);
    @(negedge core_clk_i);
    write_in_progress_flag_i = 1'b0;
    fbl_host_inst.recover();
    $display("test soft_reset done");
    fbl_host_inst.wr_cmd(OPC_FREEALL, 0, 24'h0);
    fbl_host_inst.cmd(OPC_WRITE_ENABLE_CMD, 0, 24'h0);
    fbl_host_inst.pin(1'b0);
    #250;
    fbl_host_inst.pin(1'b1);
    chk("resets", rst_cnt, n + 1);
    lk(24'h050000, 1'b0);
    fbl_host_inst.send(OPC_LKREAD, 3, 24'h050000);
    #30;
    chk("io_oe_o", io_oe_o, 4'h2);
    fbl_host_inst.pin(1'b0);
    #40;
    chk("io_oe_o", io_oe_o, 4'h0);
    #1500;
    fbl_host_inst.pin(1'b1);
    fbl_host_inst.stop();
    chk("resets", rst_cnt, n + 2);
    lk(24'h050000, 1'b1);
    chk("wel", write_enable_latch_o, 1'b0);
    fbl_host_inst.recover();
    $display("test pin_reset done");
    rd(OPC_UIDRD, 24'h0, 0, 4, 16, v);
    chk("unique_id", v, UID);
    rd(OPC_TBLRD, 24'h000010, 3, 1, 3, v);
    chk("table", v, {8'h10 ^ 8'ha5, 8'h11 ^ 8'ha5, 8'h12 ^ 8'ha5});
    $display("test id_table done");
    final_report();
  end
endmodule : testbench
`default_nettype wire
